// ===== sim/tb_top.sv
`timescale 1ns/1ns
module tb_top
    import flb_pkg::*;
;
    logic        clk, rst_n, scanTick, runtimeReset, shiftEnablePin, shiftPulsePin, sampleNow, editActive;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, pA, pN, pP, ea;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, shiftCoils;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, shiftBank, eb, ed;
    logic [5:0]  shiftFirst, ef;
    logic [6:0]  gateOut, eg;
    logic [4:0]  keys;
    logic [27:0] gateInputs, cn;
    logic [15:0] lut;
    int          error_cnt, samples_checked, seed, pos, num, i, k;
    logic [1:0]  bQ[$];
    logic [33:0] rQ[$];
    logic [23:0] pQ[$];

    flb_fbd_logic flb_fbd_logic_i (
        .clk, .rst_n, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .scanTick, .runtimeReset, .gateInputs, .shiftEnablePin, .shiftPulsePin,
        .keySelPin(keys[0]), .keyOkPin(keys[1]), .escape_keyPin(keys[2]), .keyUpPin(keys[3]),
        .keyDownPin(keys[4]), .shiftCoils, .shiftBank, .shiftFirst, .gateOut, .editActive
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [33:0] g, input logic [33:0] e);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] t=%0t got %h expected %h", $time, g, e);
        end
    endtask : chk

    // Results are matched in arrival order, so every driver notes its expectation before it asks.
    always @(posedge clk) begin
        if (s_axi_bvalid && s_axi_bready) chk(34'(s_axi_bresp), 34'(bQ.pop_front()));
        if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, rQ.pop_front());
        if (sampleNow) chk(34'({editActive, shiftBank, shiftFirst, gateOut, shiftCoils}), 34'(pQ.pop_front()));
    end

    task automatic tmo(input int n);
        if (n == 50) begin
            error_cnt++;
            report_and_stop();
        end
    endtask : tmo

    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        int n;
        bQ.push_back(er);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        tmo(n);
        @(posedge clk);
    endtask : axw

    task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        rQ.push_back({er, d});
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        tmo(n);
        @(posedge clk);
    endtask : axr

    task automatic smp;
        pQ.push_back({ea, eb, ef, eg, 8'h01 << pos});
        sampleNow <= 1'b1;
        @(posedge clk);
        sampleNow <= 1'b0;
    endtask : smp

    task automatic scan(input logic p, input logic en, input bit ck);
        logic [27:0] e;
        shiftPulsePin  <= p;
        shiftEnablePin <= en;
        gateInputs     <= 28'($random(seed));
        repeat (4) @(posedge clk);
        scanTick <= 1'b1;
        @(posedge clk);
        scanTick <= 1'b0;
        @(posedge clk);
        e  = (gateInputs & cn) | (~cn & 28'h000FFFF);
        eg = {lut[e[27:24]], e[20] ^ e[21], |e[19:16], ~&e[15:12] & pN, ~&e[11:8], &e[7:4] & ~pA, &e[3:0]};
        pA = &e[7:4];
        pN = &e[15:12];
        if (en && p && !pP) pos = (pos + 1) % num;
        pP = p;
        if (ck) smp();
    endtask : scan

    task automatic key(input int w);
        keys <= 5'h01 << w;
        repeat (6) @(posedge clk);
        keys <= 5'h00;
        repeat (6) @(posedge clk);
    endtask : key

    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, sampleNow} = 6'h00;
        {scanTick, runtimeReset, shiftEnablePin, shiftPulsePin, keys, gateInputs} = 37'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
        {eb, ef, ed, ea, pA, pN, pP, cn, lut} = 58'h0;
        seed = 32'h07A1;
        pos  = 0;
        num  = 1;
        rst_n = 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (i = 0; i <= 32; i += 4) axr(8'(i), (i == 0) ? 32'h100 : 32'h0, RESP_OKAY);
        axr(8'h24, 32'h0, RESP_SLVERR);
        axw(ADDR_STATUS, 32'hFFFF, 4'hF, RESP_SLVERR);
        lut = 16'h15A8;
        axw(ADDR_LUT, 32'hFFFF15A8, 4'h3, RESP_OKAY);
        axr(ADDR_LUT, 32'h15A8, RESP_OKAY);
        $display("test registers done");
        // The first scan is not checked; it only primes the stored edge conditions, which reset to 0.
        scan(1'b0, 1'b0, 1'b0);
        for (i = 0; i < 60; i++) begin
            if (i == 20 || i == 40) begin
                cn  = 28'($random(seed) & $random(seed));
                lut = (i == 40) ? 16'($random(seed)) : lut;
                axw(ADDR_CONN, 32'(cn), 4'hF, RESP_OKAY);
                axw(ADDR_LUT, 32'(lut), 4'hF, RESP_OKAY);
            end
            scan(1'b0, 1'b0, 1'b1);
        end
        $display("test gates done");
        for (k = 0; k < 2; k++) begin
            num = k ? 8 : 3;
            eb  = k ? BANK_MAIN : BANK_AUXA;
            ef  = k ? 6'h00 : 6'h05;
            pos = 0;
            axw(ADDR_SHIFT, {20'h0, 4'(num), ef, eb}, 4'hF, RESP_OKAY);
            smp();
            for (i = 0; i < 2 * num + 2; i++) scan(i[0], 1'b1, 1'b1);
            scan(1'b0, 1'b0, 1'b1);
            scan(1'b1, 1'b0, 1'b1);
            axw(ADDR_SHIFT, 32'h900, 4'hF, RESP_OKAY);
            smp();
        end
        $display("test shift done");
        for (i = 0; i < 9; i++) axw(ADDR_TIMER, 32'(i), 4'hF, RESP_OKAY);
        axr(ADDR_TIMER, 32'h00A, RESP_OKAY);
        for (i = 0; i < 239; i++) axw(ADDR_TIMER, 32'h1, 4'hF, RESP_OKAY);
        axw(ADDR_TIMER, 32'h7, 4'hF, RESP_OKAY);
        axr(ADDR_TIMER, 32'h1F9, RESP_OKAY);
        axw(ADDR_TIMER, 32'h1, 4'hF, RESP_OKAY);
        axw(ADDR_TIMER, 32'h1, 4'hF, RESP_OKAY);
        axw(ADDR_TIMER, 32'h9, 4'hF, RESP_OKAY);
        axr(ADDR_TIMER, 32'h1FA, RESP_OKAY);
        axw(ADDR_TIMER, 32'h30, 4'hF, RESP_OKAY);
        axr(ADDR_TIMER, 32'h0, RESP_OKAY);
        axw(ADDR_TIMER, 32'h29, 4'hF, RESP_OKAY);
        axr(ADDR_TIMER, 32'h100, RESP_OKAY);
        for (k = 0; k < 2; k++) begin
            axw(ADDR_RETAIN, 32'(k), 4'hF, RESP_OKAY);
            axw(ADDR_TMR14, 32'h1234, 4'hF, RESP_OKAY);
            axw(ADDR_TMR15, 32'h5678, 4'hF, RESP_OKAY);
            runtimeReset <= 1'b1;
            @(posedge clk);
            runtimeReset <= 1'b0;
            @(posedge clk);
            axr(ADDR_TMR14, k ? 32'h1234 : 32'h0, RESP_OKAY);
            axr(ADDR_TMR15, k ? 32'h5678 : 32'h0, RESP_OKAY);
        end
        $display("test timers done");
        axw(ADDR_PRESET, 32'h10, 4'hF, RESP_OKAY);
        key(1);
        ed = 2'h1;
        axr(ADDR_STATUS, {18'h0, ed, 1'b0, 3'(pos), 1'b0, eg}, RESP_OKAY);
        key(0);
        ea = 1'b1;
        smp();
        key(3);
        key(3);
        key(1);
        ea = 1'b0;
        axr(ADDR_PRESET, 32'h12, RESP_OKAY);
        key(0);
        key(4);
        key(2);
        axr(ADDR_PRESET, 32'h12, RESP_OKAY);
        axr(ADDR_STATUS, {18'h0, ed, 1'b0, 3'(pos), 1'b0, eg}, RESP_OKAY);
        key(2);
        ed = 2'h0;
        axr(ADDR_STATUS, {18'h0, ed, 1'b0, 3'(pos), 1'b0, eg}, RESP_OKAY);
        axw(ADDR_PRESET, 32'h0000AB00, 4'h2, RESP_OKAY);
        axr(ADDR_PRESET, 32'hAB12, RESP_OKAY);
        $display("test editor done");
        report_and_stop();
    end
endmodule : tb_top

// ===== verilog/flb_fbd_logic.sv
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
module flb_fbd_logic
    import flb_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic [2:0]           s_axi_awprot,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [ADDR_W-1:0]    s_axi_araddr,
    input  wire logic [2:0]           s_axi_arprot,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    input  wire logic                 scanTick,
    input  wire logic                 runtimeReset,
    input  wire logic [27:0]          gateInputs,
    input  wire logic                 shiftEnablePin,
    input  wire logic                 shiftPulsePin,
    input  wire logic                 keySelPin,
    input  wire logic                 keyOkPin,
    input  wire logic                 escape_keyPin,
    input  wire logic                 keyUpPin,
    input  wire logic                 keyDownPin,
    output logic [7:0]                shiftCoils,
    output logic [1:0]                shiftBank,
    output logic [5:0]                shiftFirst,
    output logic [GATE_N-1:0]         gateOut,
    output logic                      editActive
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Pins are asynchronous to clk; only sync2_q and its delayed copy keyPrev_q are looked at by logic.
    logic [6:0]  sync1_q, sync2_q, keyPrev_q;
    logic        shEnS, shPulseS, keySel, keyOk, keyEsc, keyUp, keyDown;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1_q   <= 7'h00;
            sync2_q   <= 7'h00;
            keyPrev_q <= 7'h00;
        end else begin
            sync1_q   <= {keyDownPin, keyUpPin, escape_keyPin, keyOkPin, keySelPin, shiftPulsePin, shiftEnablePin};
            sync2_q   <= sync1_q;
            keyPrev_q <= sync2_q;
        end
    end
    assign shEnS    = sync2_q[0];
    assign shPulseS = sync2_q[1];
    assign keySel   = sync2_q[2] & ~keyPrev_q[2];
    assign keyOk    = sync2_q[3] & ~keyPrev_q[3];
    assign keyEsc   = sync2_q[4] & ~keyPrev_q[4];
    assign keyUp    = sync2_q[5] & ~keyPrev_q[5];
    assign keyDown  = sync2_q[6] & ~keyPrev_q[6];

    function automatic logic [31:0] mergeStrb(input logic [31:0] oldV, input logic [31:0] newV,
                                              input logic [3:0] strb);
        logic [31:0] r;
        r = oldV;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = newV[b*8 +: 8];
            end
        end
        return r;
    endfunction : mergeStrb

    // Write channel: address and data are held independently, then used together.
    logic [ADDR_W-1:0] awAddr_q;
    logic [31:0]       wData_q;
    logic [3:0]        wStrb_q;
    logic              awHeld_q, wHeld_q, wrFire, wrHit;
    logic [31:0]       rdMux, wrMerged;
    assign wrFire = awHeld_q & wHeld_q & ~s_axi_bvalid;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            awHeld_q      <= 1'b0;
            wHeld_q       <= 1'b0;
            awAddr_q      <= '0;
            wData_q       <= 32'h00000000;
            wStrb_q       <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_q      <= 1'b1;
                awAddr_q      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_q      <= 1'b1;
                wData_q      <= s_axi_wdata;
                wStrb_q      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wrFire) begin
                awHeld_q     <= 1'b0;
                wHeld_q      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wrHit ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Status is read-only, so a write to it is answered as an error.
    assign wrHit = (awAddr_q == ADDR_SHIFT) || (awAddr_q == ADDR_CONN) || (awAddr_q == ADDR_LUT) ||
                   (awAddr_q == ADDR_TIMER) || (awAddr_q == ADDR_RETAIN) || (awAddr_q == ADDR_TMR14) ||
                   (awAddr_q == ADDR_TMR15) || (awAddr_q == ADDR_PRESET);
    assign wrMerged = mergeStrb(rdMux, wData_q, wStrb_q);

    // Configuration registers.
    logic [1:0]  shBank_q;
    logic [5:0]  shFirst_q;
    logic [3:0]  shNum_q;
    logic [27:0] conn_q;
    logic [15:0] lut_q;
    logic        retain_q, cfgWrite;
    logic [15:0] tmr14_q, tmr15_q;
    assign cfgWrite = wrFire && (awAddr_q == ADDR_SHIFT) && (wrMerged[11:8] >= NUM_MIN) &&
                      (wrMerged[11:8] <= NUM_MAX);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shBank_q  <= BANK_MAIN;
            shFirst_q <= 6'h00;
            shNum_q   <= NUM_RST;
            conn_q    <= CONN_RST;
            lut_q     <= LUT_RST;
            retain_q  <= 1'b0;
        end else if (wrFire) begin
            if (cfgWrite) begin
                shBank_q  <= wrMerged[1:0];
                shFirst_q <= wrMerged[7:2];
                shNum_q   <= wrMerged[11:8];
            end
            if (awAddr_q == ADDR_CONN)   conn_q   <= wrMerged[27:0];
            if (awAddr_q == ADDR_LUT)    lut_q    <= wrMerged[15:0];
            if (awAddr_q == ADDR_RETAIN) retain_q <= wrMerged[0];
        end
    end

    // A runtime restart stands for a power cycle of the retained timer values.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tmr14_q <= TMR_RST;
            tmr15_q <= TMR_RST;
        end else if (wrFire && awAddr_q == ADDR_TMR14) begin
            tmr14_q <= wrMerged[15:0];
        end else if (wrFire && awAddr_q == ADDR_TMR15) begin
            tmr15_q <= wrMerged[15:0];
        end else if (runtimeReset && !retain_q) begin
            tmr14_q <= TMR_RST;
            tmr15_q <= TMR_RST;
        end
    end

    // Timer pool bookkeeping.
    logic [7:0] tmrUsed_q;
    logic       tmrErr_q, tmrReq, tmrAccept, tmrRelease;
    logic [3:0] tmrMode;
    logic [8:0] tmrSum;
    assign tmrReq     = wrFire && (awAddr_q == ADDR_TIMER);
    assign tmrMode    = wrMerged[3:0];
    assign tmrRelease = wrMerged[TR_RELEASE];
    assign tmrSum     = {1'b0, tmrUsed_q} + ((tmrMode == MODE_DOUBLE) ? 9'h002 : 9'h001);
    assign tmrAccept  = tmrReq && !tmrRelease && (tmrMode <= MODE_MAX) && (tmrSum <= {1'b0, TIMER_POOL});
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tmrUsed_q <= 8'h00;
            tmrErr_q  <= 1'b0;
        end else begin
            if (tmrReq && tmrRelease) tmrUsed_q <= 8'h00;
            else if (tmrAccept)       tmrUsed_q <= tmrSum[7:0];
            // A refusal in the same write as the clear still leaves the flag set.
            tmrErr_q <= (tmrReq && !tmrRelease && !tmrAccept) ||
                        (tmrErr_q && !(tmrReq && wrMerged[TR_CLRERR]));
        end
    end

    // Shift sequencer, the single instance of this block.
    logic [2:0] shPos_q, shPos_d, posNext;
    logic [3:0] posInc;
    logic       pulsePrev_q, shStep;
    assign posInc  = {1'b0, shPos_q} + 4'h1;
    assign posNext = (posInc >= shNum_q) ? 3'h0 : posInc[2:0];
    assign shStep  = scanTick && shEnS && shPulseS && !pulsePrev_q;
    always_comb begin
        if (cfgWrite)    shPos_d = 3'h0;
        else if (shStep) shPos_d = posNext;
        else             shPos_d = shPos_q;
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shPos_q     <= 3'h0;
            pulsePrev_q <= 1'b0;
            shiftCoils  <= 8'h01;
            shiftBank   <= BANK_MAIN;
            shiftFirst  <= 6'h00;
        end else begin
            if (scanTick) pulsePrev_q <= shPulseS;
            shPos_q    <= shPos_d;
            shiftCoils <= 8'(8'h01 << shPos_d);
            shiftBank  <= shBank_q;
            shiftFirst <= shFirst_q;
        end
    end

    // Gate blocks, evaluated once per scan.
    logic [GATE_N-1:0] gateNext, allCond;
    genvar g;
    generate
        for (g = 0; g < GATE_N; g++) begin : gGate
            logic [GATE_IN_W-1:0] raw, eff, conn;
            assign raw  = gateInputs[g*GATE_IN_W +: GATE_IN_W];
            assign conn = conn_q[g*GATE_IN_W +: GATE_IN_W];
            if (g <= G_ENAND) begin : gHi
                assign eff = raw | ~conn;
            end else begin : gLo
                assign eff = raw & conn;
            end
            assign allCond[g] = &eff;
            if (g == G_AND) begin : gAnd
                assign gateNext[g] = allCond[g];
            end else if (g == G_NAND) begin : gNand
                assign gateNext[g] = ~allCond[g];
            end else if (g == G_OR) begin : gOr
                assign gateNext[g] = |eff;
            end else if (g == G_XOR) begin : gXor
                assign gateNext[g] = eff[0] ^ eff[1];
            end else if (g == G_BOOL) begin : gBool
                assign gateNext[g] = lut_q[eff];
            end else begin : gEdge
                logic prev_q;
                always_ff @(posedge clk) begin
                    if (!rst_n) prev_q <= 1'b0;
                    else if (scanTick) prev_q <= allCond[g];
                end
                if (g == G_EAND) begin : gRise
                    assign gateNext[g] = allCond[g] & ~prev_q;
                end else begin : gFall
                    assign gateNext[g] = ~allCond[g] & prev_q;
                end
            end
        end
    endgenerate
    always_ff @(posedge clk) begin
        if (!rst_n) gateOut <= '0;
        else if (scanTick) gateOut <= gateNext;
    end

    // Parameter editor driven by the front-panel keys.
    flb_edit_t   edState_q;
    logic [15:0] editVal_q, preset_q;
    logic        edSave, presetWrite;
    assign edSave      = (edState_q == ED_EDIT) && keyOk;
    assign presetWrite = wrFire && (awAddr_q == ADDR_PRESET);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            edState_q  <= ED_IDLE;
            editVal_q  <= PRESET_RST;
            editActive <= 1'b0;
        end else begin
            editActive <= (edState_q == ED_EDIT);
            case (edState_q)
                ED_IDLE: begin
                    if (keyOk) edState_q <= ED_SHOW;
                end
                ED_SHOW: begin
                    if (keySel) begin
                        edState_q <= ED_EDIT;
                        editVal_q <= preset_q;
                    end else if (keyEsc) begin
                        edState_q <= ED_IDLE;
                    end
                end
                ED_EDIT: begin
                    if (keyOk || keyEsc) edState_q <= ED_SHOW;
                    else if (keyUp)      editVal_q <= editVal_q + 16'h0001;
                    else if (keyDown)    editVal_q <= editVal_q - 16'h0001;
                end
                default: edState_q <= ED_IDLE;
            endcase
        end
    end
    // Software wins over a simultaneous key save; the panel simply shows the new value.
    always_ff @(posedge clk) begin
        if (!rst_n)           preset_q <= PRESET_RST;
        else if (presetWrite) preset_q <= wrMerged[15:0];
        else if (edSave)      preset_q <= editVal_q;
    end

    // Read channel.
    function automatic logic [31:0] regRead(input logic [ADDR_W-1:0] a);
        case (a)
            ADDR_SHIFT:  regRead = {20'h00000, shNum_q, shFirst_q, shBank_q};
            ADDR_CONN:   regRead = {4'h0, conn_q};
            ADDR_LUT:    regRead = {16'h0000, lut_q};
            ADDR_STATUS: regRead = {18'h0, edState_q, 1'b0, shPos_q, 1'b0, gateOut};
            ADDR_TIMER:  regRead = {23'h0, tmrErr_q, tmrUsed_q};
            ADDR_RETAIN: regRead = {31'h0, retain_q};
            ADDR_TMR14:  regRead = {16'h0000, tmr14_q};
            ADDR_TMR15:  regRead = {16'h0000, tmr15_q};
            ADDR_PRESET: regRead = {16'h0000, preset_q};
            default:     regRead = 32'h00000000;
        endcase
    endfunction : regRead
    // Byte-lane writes merge into what the addressed register holds now.
    assign rdMux = regRead(awAddr_q);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= regRead(s_axi_araddr);
            s_axi_rresp   <= (s_axi_araddr <= ADDR_PRESET && s_axi_araddr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    property p_shiftOneHot;
        $onehot(shiftCoils) && (shPos_q < shNum_q[2:0] || shNum_q == NUM_MAX);
    endproperty
    a_shiftOneHot: assert property (p_shiftOneHot) else $error("shift output not one-hot in group");
    property p_shiftAdvance;
        shStep && !cfgWrite |=> shPos_q == $past(posNext) ##1 shiftCoils == 8'(8'h01 << $past(shPos_q));
    endproperty
    a_shiftAdvance: assert property (p_shiftAdvance) else $error("shift did not advance");
    property p_andOut;
        scanTick |=> gateOut[G_AND] == $past(allCond[G_AND]) && gateOut[G_NAND] == !$past(allCond[G_NAND]);
    endproperty
    a_andOut: assert property (p_andOut) else $error("and or nand output wrong");
    // A pulse leaves the stored condition at its new level, so the next scan must not pulse again.
    property p_edgeAnd;
        scanTick && gateOut[G_EAND] |=> !gateOut[G_EAND];
    endproperty
    a_edgeAnd: assert property (p_edgeAnd) else $error("edge and pulse longer than one scan");
    property p_edgeNand;
        scanTick && gateOut[G_ENAND] |=> !gateOut[G_ENAND];
    endproperty
    a_edgeNand: assert property (p_edgeNand) else $error("edge nand pulse longer than one scan");
    property p_orXor;
        scanTick |=> gateOut[G_OR] == |$past(gGate[G_OR].eff) &&
                     gateOut[G_XOR] == ($past(gGate[G_XOR].eff[0]) ^ $past(gGate[G_XOR].eff[1]));
    endproperty
    a_orXor: assert property (p_orXor) else $error("or or xor output wrong");
    property p_bool;
        scanTick |=> gateOut[G_BOOL] == $past(lut_q[gGate[G_BOOL].eff]);
    endproperty
    a_bool: assert property (p_bool) else $error("lookup output wrong");
    property p_timerCap;
        tmrUsed_q <= TIMER_POOL;
    endproperty
    a_timerCap: assert property (p_timerCap) else $error("timer pool exceeded");
    property p_mode7;
        tmrAccept && tmrMode == MODE_DOUBLE |=> tmrUsed_q == $past(tmrUsed_q) + 8'h02;
    endproperty
    a_mode7: assert property (p_mode7) else $error("mode seven did not take two timers");
    property p_retain;
        runtimeReset && retain_q && !wrFire |=> $stable(tmr14_q) && $stable(tmr15_q);
    endproperty
    a_retain: assert property (p_retain) else $error("retained timer lost");
    property p_escape;
        edState_q == ED_EDIT && keyEsc && !keyOk && !presetWrite |=> edState_q == ED_SHOW && $stable(preset_q);
    endproperty
    a_escape: assert property (p_escape) else $error("escape did not cancel edit");
endmodule : flb_fbd_logic

// ===== verilog/flb_pkg.sv
// Overview of operation
// - Exactly one shift sequencer instance exists.
// - Group spans one to eight contacts, selectable start.
// - AND-family unconnected inputs read as high.
// - OR, XOR, lookup unconnected inputs read low.
// - AND output on when all inputs on.
// - Edge AND pulses one scan on all-on.
// - NAND output on when any input off.
// - Edge NAND pulses one scan leaving all-on.
// - OR output on when any input on.
// - XOR output on when two inputs differ.
// - Lookup block indexes 16-bit table, input one low.
// - At most 250 timers, modes zero to eight.
// - Mode seven timer consumes two pool entries.
// - Retention keeps timers fourteen and fifteen values.
// - Select edits, confirm saves, escape cancels or leaves.
package flb_pkg;
    localparam int unsigned ADDR_W        = 8;
    localparam logic [7:0]  ADDR_SHIFT    = 8'h00;
    localparam logic [7:0]  ADDR_CONN     = 8'h04;
    localparam logic [7:0]  ADDR_LUT      = 8'h08;
    localparam logic [7:0]  ADDR_STATUS   = 8'h0C;
    localparam logic [7:0]  ADDR_TIMER    = 8'h10;
    localparam logic [7:0]  ADDR_RETAIN   = 8'h14;
    localparam logic [7:0]  ADDR_TMR14    = 8'h18;
    localparam logic [7:0]  ADDR_TMR15    = 8'h1C;
    localparam logic [7:0]  ADDR_PRESET   = 8'h20;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
    localparam int unsigned GATE_N        = 7;
    localparam int unsigned GATE_IN_W     = 4;
    localparam int unsigned G_AND         = 0;
    localparam int unsigned G_EAND        = 1;
    localparam int unsigned G_NAND        = 2;
    localparam int unsigned G_ENAND       = 3;
    localparam int unsigned G_OR          = 4;
    localparam int unsigned G_XOR         = 5;
    localparam int unsigned G_BOOL        = 6;
    localparam logic [3:0]  NUM_MIN       = 4'h1;
    localparam logic [3:0]  NUM_MAX       = 4'h8;
    localparam logic [3:0]  NUM_RST       = 4'h1;
    localparam logic [7:0]  TIMER_POOL    = 8'hFA;
    localparam logic [3:0]  MODE_MAX      = 4'h8;
    localparam logic [3:0]  MODE_DOUBLE   = 4'h7;
    localparam int unsigned TR_RELEASE    = 4;
    localparam int unsigned TR_CLRERR     = 5;
    localparam logic [15:0] LUT_RST       = 16'h0000;
    localparam logic [27:0] CONN_RST      = 28'h0000000;
    localparam logic [15:0] PRESET_RST    = 16'h0000;
    localparam logic [15:0] TMR_RST       = 16'h0000;
    typedef enum logic [1:0] {BANK_MAIN, BANK_EXT, BANK_AUXA, BANK_AUXB} flb_bank_t;
    typedef enum logic [1:0] {ED_IDLE, ED_SHOW, ED_EDIT} flb_edit_t;
endpackage : flb_pkg
